// [tlf_map.svh]
//
// Contract
// - Eight-bit thermal assertion limit, each count one 22.76 ms step.
// - Assertion time beyond the limit sets bit 5 of interrupt status 0x42.
// - Limit zero raises the interrupt at once on thermal assertion.
// - Per fan two-bit code picks one to four tach pulses; default two.
// - Fan one bits 1:0 up to fan four bits 7:6; reset 0x55.
// - Alert-on-aux bit set turns the shared 2.5 V pin into alert output.
// - Thermal pin select gives the 5 V pin the thermal input function.
// - Bits 3:2 of config register 4 pick the 2-wire fan threshold.
// - Limit and config register 4 reset to zero.
// - Assertion sets a read-cleared flag; past 45.52 ms it is timer LSB.
// - Thermal monitoring only while thermal enable bit 1 of config 3 set.
`ifndef TLF_MAP_SVH
`define TLF_MAP_SVH

// ****************************************
// Register indices (byte address is 4x)
// ****************************************
`define TLF_IDX_INT_STAT 8'h42
`define TLF_IDX_CFG3 8'h78
`define TLF_IDX_THERM_STAT 8'h79
`define TLF_IDX_LIMIT 8'h7a
`define TLF_IDX_PULSE 8'h7b
`define TLF_IDX_PIN_CFG 8'h7d
`define TLF_IDX_TEST1 8'h7e
`define TLF_IDX_TEST2 8'h7f
`define TLF_IDX_INT_MASK 8'h81

// ****************************************
// Reset values
// ****************************************
`define TLF_RST_LIMIT 8'h00
`define TLF_RST_PULSE 8'h55
`define TLF_RST_PIN_CFG 8'h00
`define TLF_RST_CFG3 8'h00
`define TLF_RST_MASK 8'h00
`define TLF_RST_TEST 8'h00
`define TLF_RST_INT 8'h00

// ****************************************
// Field positions
// ****************************************
`define TLF_BIT_THERM_EVT 5
`define TLF_BIT_ALERT_AUX 0
`define TLF_BIT_THERM_SEL 1
`define TLF_BIT_THERM_EN 1
`define TLF_BIT_BOOST 2
`define TLF_THR_HI 3
`define TLF_THR_LO 2
`define TLF_BIT_ASRT 0

// ****************************************
// Timing
// ****************************************
`define TLF_TICK_US 22760
`define TLF_CLK_NS 50
`define TLF_TICK_CYCLES ((`TLF_TICK_US * 1000) / `TLF_CLK_NS)
`define TLF_TMR_VISIBLE 8'h02
`define TLF_ADDR_W 12

`endif

// [tlf_pkg.sv]
`default_nettype none
package tlf_pkg;

  // Tach pulse counts, one code per fan
  typedef struct packed {
    logic [1:0] fan_four_pulse_count;
    logic [1:0] fan_three_pulse_count;
    logic [1:0] fan_two_pulse_count;
    logic [1:0] fan_one_pulse_count;
  } tlf_pulse_s;

  // Control view handed to the fan and pin logic
  typedef struct packed {
    tlf_pulse_s pulses;
    logic [1:0] two_wire_threshold;
    logic thermal_pin_select;
    logic full_speed;
  } tlf_ctl_s;

endpackage
`default_nettype wire

// [tlf_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module tlf_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_reg;

  // Two stages; reset value is the idle (high) pin level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b1;
      sync_o <= 1'b1;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// [tlf_top.sv]
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "tlf_map.svh"
module tlf_top #(
  parameter int unsigned TICK_CYCLES = `TLF_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`TLF_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic therm_n_i,
  input wire logic aux_pin_i,
  output logic aux_pin_o,
  output logic aux_pin_oe_o,
  output logic aux_meas_en_o,
  output tlf_pkg::tlf_ctl_s ctl_o,
  output logic irq_o
);
  import tlf_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0] limit_reg;
  logic [7:0] pulse_reg;
  logic [7:0] pin_cfg_reg;
  logic [7:0] cfg3_reg;
  logic [7:0] mask_reg;
  logic [7:0] int_stat_reg;
  logic [7:0] tmr_reg;
  logic asrt_reg;
  logic [31:0] tick_reg;
  logic tmr_upd_reg;
  logic therm_sync;
  logic therm_act;
  logic therm_act_d_reg;
  logic therm_rise;
  logic tick_done;
  logic apb_done;
  logic apb_wr;
  logic apb_rd;
  logic [7:0] rd_data;
  logic rd_mapped;
  logic [7:0] therm_view;
  logic [7:0] int_set;
  logic aux_unused;

  // ****************************************
  // Helpers
  // ****************************************
  // Word-aligned hit on a register index
  function automatic logic addr_hit(input logic [`TLF_ADDR_W-1:0] a,
                                    input logic [7:0] idx);
    addr_hit = (a == {2'b00, idx, 2'b00});
  endfunction

  // Write of lane 0 to one register
  function automatic logic wr_hit(input logic wr,
                                  input logic [`TLF_ADDR_W-1:0] a,
                                  input logic [7:0] idx,
                                  input logic lane);
    wr_hit = wr & lane & addr_hit(a, idx);
  endfunction

  // ****************************************
  // APB slave handshake
  // ****************************************
  // One wait state keeps read data a registered copy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= psel_i & penable_i & ~pready_o;
    end
  end

  assign apb_done = psel_i & penable_i & pready_o;
  assign apb_wr = apb_done & pwrite_i;
  assign apb_rd = apb_done & ~pwrite_i;

  // Read multiplexer; test registers stay at zero
  always_comb begin
    rd_data = 8'h00;
    rd_mapped = 1'b1;
    if (addr_hit(paddr_i, `TLF_IDX_LIMIT)) begin
      rd_data = limit_reg;
    end else if (addr_hit(paddr_i, `TLF_IDX_PULSE)) begin
      rd_data = pulse_reg;
    end else if (addr_hit(paddr_i, `TLF_IDX_PIN_CFG)) begin
      rd_data = pin_cfg_reg;
    end else if (addr_hit(paddr_i, `TLF_IDX_CFG3)) begin
      rd_data = cfg3_reg;
    end else if (addr_hit(paddr_i, `TLF_IDX_THERM_STAT)) begin
      rd_data = therm_view;
    end else if (addr_hit(paddr_i, `TLF_IDX_INT_STAT)) begin
      rd_data = int_stat_reg;
    end else if (addr_hit(paddr_i, `TLF_IDX_INT_MASK)) begin
      rd_data = mask_reg;
    end else if (addr_hit(paddr_i, `TLF_IDX_TEST1) ||
                 addr_hit(paddr_i, `TLF_IDX_TEST2)) begin
      rd_data = `TLF_RST_TEST;
    end else begin
      rd_mapped = 1'b0;
    end
  end

  // Data and error land together with pready
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (psel_i & penable_i & ~pready_o) begin
      prdata_o <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_data};
      pslverr_o <= ~rd_mapped;
    end else begin
      pslverr_o <= 1'b0;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  // Limit register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      limit_reg <= `TLF_RST_LIMIT;
    end else if (wr_hit(apb_wr, paddr_i, `TLF_IDX_LIMIT, pstrb_i[0])) begin
      limit_reg <= pwdata_i[7:0];
    end
  end

  // Pulse count selection, two bits per fan
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_reg <= `TLF_RST_PULSE;
    end else if (wr_hit(apb_wr, paddr_i, `TLF_IDX_PULSE, pstrb_i[0])) begin
      pulse_reg <= pwdata_i[7:0];
    end
  end

  // Pin function config; upper nibble unused, reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_cfg_reg <= `TLF_RST_PIN_CFG;
    end else if (wr_hit(apb_wr, paddr_i, `TLF_IDX_PIN_CFG, pstrb_i[0])) begin
      pin_cfg_reg <= {4'h0, pwdata_i[3:0]};
    end
  end

  // Config register 3 and the interrupt mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg3_reg <= `TLF_RST_CFG3;
      mask_reg <= `TLF_RST_MASK;
    end else begin
      if (wr_hit(apb_wr, paddr_i, `TLF_IDX_CFG3, pstrb_i[0])) begin
        cfg3_reg <= pwdata_i[7:0];
      end
      if (wr_hit(apb_wr, paddr_i, `TLF_IDX_INT_MASK, pstrb_i[0])) begin
        mask_reg <= pwdata_i[7:0];
      end
    end
  end

  // ****************************************
  // Thermal input and timer
  // ****************************************
  tlf_sync u_therm_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(therm_n_i),
    .sync_o(therm_sync)
  );

  // Active only with both the pin function and the enable bit
  assign therm_act = ~therm_sync & cfg3_reg[`TLF_BIT_THERM_EN] &
                     pin_cfg_reg[`TLF_BIT_THERM_SEL];
  assign therm_rise = therm_act & ~therm_act_d_reg;
  assign tick_done = therm_act && (tick_reg == TICK_CYCLES - 1);

  // Edge history of the gated thermal level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      therm_act_d_reg <= 1'b0;
    end else begin
      therm_act_d_reg <= therm_act;
    end
  end

  // Step counter; partial steps are dropped on release
  always_ff @(posedge clk_i) begin
    if (rst_i || !therm_act || tick_done) begin
      tick_reg <= 32'h0000_0000;
    end else begin
      tick_reg <= tick_reg + 32'h0000_0001;
    end
  end

  // Accumulated time, saturating; a read clears, a new step wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_reg <= 8'h00;
      tmr_upd_reg <= 1'b0;
    end else begin
      tmr_upd_reg <= tick_done;
      if (apb_rd && addr_hit(paddr_i, `TLF_IDX_THERM_STAT)) begin
        tmr_reg <= tick_done ? 8'h01 : 8'h00;
      end else if (tick_done && tmr_reg != 8'hff) begin
        tmr_reg <= tmr_reg + 8'h01;
      end
    end
  end

  // Assertion flag, cleared on read unless a new assertion lands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      asrt_reg <= 1'b0;
    end else if (therm_rise) begin
      asrt_reg <= 1'b1;
    end else if (apb_rd && addr_hit(paddr_i, `TLF_IDX_THERM_STAT)) begin
      asrt_reg <= 1'b0;
    end
  end

  // Flag alone below two steps, full timer afterwards
  assign therm_view = (tmr_reg >= `TLF_TMR_VISIBLE) ? tmr_reg :
                      {7'h00, asrt_reg};

  // ****************************************
  // Interrupt status and output
  // ****************************************
  // Zero limit fires on assertion, else on first timer excess
  always_comb begin
    int_set = 8'h00;
    int_set[`TLF_BIT_THERM_EVT] =
      (therm_rise && limit_reg == 8'h00) ||
      (tmr_upd_reg && limit_reg != 8'h00 && tmr_reg > limit_reg);
  end

  // Sticky bits; a set in the clearing read's cycle survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_stat_reg <= `TLF_RST_INT;
    end else if (apb_rd && addr_hit(paddr_i, `TLF_IDX_INT_STAT)) begin
      int_stat_reg <= int_set;
    end else begin
      int_stat_reg <= int_stat_reg | int_set;
    end
  end

  // Mask bit high hides the matching status bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(int_stat_reg & ~mask_reg);
    end
  end

  // ****************************************
  // Pin functions and control view
  // ****************************************
  // Aux pin: alert output (low while pending) or measurement input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_pin_oe_o <= 1'b0;
      aux_pin_o <= 1'b1;
      aux_meas_en_o <= 1'b1;
    end else begin
      aux_pin_oe_o <= pin_cfg_reg[`TLF_BIT_ALERT_AUX];
      aux_pin_o <= ~(|(int_stat_reg & ~mask_reg));
      aux_meas_en_o <= ~pin_cfg_reg[`TLF_BIT_ALERT_AUX];
    end
  end

  // Measurement path reads the aux pin elsewhere
  assign aux_unused = aux_pin_i;

  // Registered control copy for fan and pin logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_o <= '0;
    end else begin
      ctl_o.pulses <= tlf_pulse_s'(pulse_reg);
      ctl_o.two_wire_threshold <=
        pin_cfg_reg[`TLF_THR_HI:`TLF_THR_LO];
      ctl_o.thermal_pin_select <= pin_cfg_reg[`TLF_BIT_THERM_SEL];
      ctl_o.full_speed <= therm_act & cfg3_reg[`TLF_BIT_BOOST];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  zero_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    therm_rise && limit_reg == 8'h00 |=> int_stat_reg[5])
    else $error("zero limit did not raise thermal interrupt");

  exceed_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_done && limit_reg != 8'h00 && tmr_reg >= limit_reg &&
    tmr_reg != 8'hff && !(apb_rd && addr_hit(paddr_i, `TLF_IDX_THERM_STAT))
    |=> ##1 int_stat_reg[5])
    else $error("timer excess did not set thermal interrupt");

  no_early_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tmr_upd_reg && limit_reg != 8'h00 && tmr_reg <= limit_reg &&
    !therm_rise && !int_stat_reg[5] |=> !int_stat_reg[5])
    else $error("thermal interrupt set before limit passed");

  reset_vals_a: assert property (@(posedge clk_i)
    rst_i |=> limit_reg == 8'h00 && pin_cfg_reg == 8'h00)
    else $error("limit or pin config not zero after reset");

  pulse_reset_a: assert property (@(posedge clk_i)
    rst_i ##1 !rst_i |=> ctl_o.pulses.fan_two_pulse_count == 2'b01 &&
    ctl_o.pulses == 8'h55)
    else $error("pulse count default wrong");

  aux_oe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_hit(apb_wr, paddr_i, `TLF_IDX_PIN_CFG, pstrb_i[0]) ##1 1'b1
    |=> aux_pin_oe_o == $past(pwdata_i[0], 2) &&
    aux_meas_en_o != aux_pin_oe_o)
    else $error("aux pin function not following config");

  therm_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cfg3_reg[1] && pin_cfg_reg[1]) |=> ##1 !ctl_o.full_speed &&
    !$rose(asrt_reg))
    else $error("thermal monitoring active while disabled");

  asrt_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    therm_rise |=> asrt_reg && therm_view[0])
    else $error("assertion flag not set");

  timer_view_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tmr_reg < 8'h02 |-> therm_view[7:1] == 7'h00)
    else $error("timer bits visible before two steps");

  threshold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctl_o.two_wire_threshold == $past(pin_cfg_reg[3:2]))
    else $error("threshold field not forwarded");

  tick_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_reg < TICK_CYCLES and (tick_done |=> tmr_upd_reg))
    else $error("step counter out of range");

  apb_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
    psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
    else $error("slave answer not one wait state");

  irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    int_stat_reg[5] && !mask_reg[5] |=> irq_o)
    else $error("unmasked status did not raise irq");

  zero_fire_c: cover property (@(posedge clk_i) disable iff (rst_i)
    therm_rise && limit_reg == 8'h00);
  exceed_c: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(int_stat_reg[5]) && limit_reg != 8'h00);
  irq_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
  unmapped_c: cover property (@(posedge clk_i) disable iff (rst_i)
    pslverr_o && pready_o);

endmodule
`default_nettype wire

// [tlf_far.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Thermal overload source beside the block
// ****************************************
module tlf_far (
  input wire logic clk_i,
  output logic therm_n_o,
  output logic aux_lvl_o
);
  // Pin is pulled high while released; aux level only moves in a burst
  initial begin
    therm_n_o = 1'b1;
    aux_lvl_o = 1'b0;
  end

  // 400 ns link rate, toggling on falling edges of the block clock
  always #200 if (!therm_n_o) aux_lvl_o = ~aux_lvl_o;

  // Level changes just after an edge, never on the sampling edge
  task automatic drive(input logic lvl);
    @(posedge clk_i);
    therm_n_o <= lvl;
  endtask
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tlf_map.svh"
`define CHK(nm, ex, got) begin \
  n_compared++; \
  if ((got) !== (ex)) begin \
    err_total++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); \
  end \
end
module testbench;
  import tlf_pkg::*;
  // Short tick keeps the timer runs to tens of cycles
  localparam int unsigned TICK = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h00000000;
  logic [3:0] pstrb_i = 4'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic therm_n;
  logic aux_lvl;
  logic aux_pin_o;
  logic aux_pin_oe_o;
  logic aux_meas_en_o;
  tlf_ctl_s ctl_o;
  logic irq_o;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [32:0] exp_q[$];
  logic [32:0] exp_v;

  tlf_top #(.TICK_CYCLES(TICK)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .therm_n_i(therm_n), .aux_pin_i(aux_lvl),
    .aux_pin_o(aux_pin_o), .aux_pin_oe_o(aux_pin_oe_o),
    .aux_meas_en_o(aux_meas_en_o), .ctl_o(ctl_o), .irq_o(irq_o)
  );
  tlf_far i_far (.clk_i(clk_i), .therm_n_o(therm_n), .aux_lvl_o(aux_lvl));

  always #25 clk_i = ~clk_i;

  // ****************************************
  // Closing report and hang guard
  // ****************************************
  task automatic end_sim();
    if (exp_q.size() != 0) err_total++;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end

  // Read answers are judged at the edge that takes them
  always @(posedge clk_i) begin
    if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
      exp_v = exp_q.pop_front();
      `CHK("read", exp_v, {pslverr_o, prdata_o})
    end
  end

  // ****************************************
  // Bus and timing helpers
  // ****************************************
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] d, input logic [3:0] s);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= {24'($urandom), d};
    pstrb_i <= s;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Edge-sampled pready; only the bench timeout ends a hang
    do @(posedge clk_i); while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Upper data bits and upper strobes random; lane 0 always on
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {2'b00, idx, 2'b00}, d, {3'($urandom), 1'b1});
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] d,
                    input logic err);
    exp_q.push_back({err, 24'h000000, d});
    apb(1'b0, {2'b00, idx, 2'b00}, 8'h00, 4'h0);
  endtask

  // Checks land mid-cycle, after the edge's updates
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] v;
    void'($urandom(89));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(1);
    `CHK("pulses", 8'h55, ctl_o.pulses)
    rd(`TLF_IDX_LIMIT, 8'h00, 1'b0);
    rd(`TLF_IDX_PULSE, 8'h55, 1'b0);
    rd(`TLF_IDX_PIN_CFG, 8'h00, 1'b0);
    rd(`TLF_IDX_TEST1, 8'h00, 1'b0);
    rd(`TLF_IDX_TEST2, 8'h00, 1'b0);
    // Test registers are never written; lane 0 off must drop a write
    apb(1'b1, {2'b00, `TLF_IDX_LIMIT, 2'b00}, 8'h5a, 4'he);
    rd(`TLF_IDX_LIMIT, 8'h00, 1'b0);
    rd(`TLF_IDX_TEST1, 8'h00, 1'b0);
    rd(8'h10, 8'h00, 1'b1);
    // Misaligned word with stray upper address bits is unmapped
    exp_q.push_back({1'b1, 32'h0000_0000});
    apb(1'b0, {2'b11, `TLF_IDX_LIMIT, 2'b01}, 8'h00, 4'h0);
    $display("test reset_values done");
    v = 8'($urandom);
    wr(`TLF_IDX_LIMIT, v);
    rd(`TLF_IDX_LIMIT, v, 1'b0);
    for (int k = 0; k < 4; k++) begin
      v = {4{k[1:0]}};
      wr(`TLF_IDX_PULSE, v);
      rd(`TLF_IDX_PULSE, v, 1'b0);
      settle(2);
      `CHK("pulses", v, ctl_o.pulses)
      v = {4'($urandom), k[1:0], k[0], k[1]};
      wr(`TLF_IDX_PIN_CFG, v);
      rd(`TLF_IDX_PIN_CFG, {4'h0, v[3:0]}, 1'b0);
      settle(2);
      `CHK("threshold", v[3:2], ctl_o.two_wire_threshold)
      `CHK("pin_sel", v[1], ctl_o.thermal_pin_select)
      `CHK("aux_oe", v[0], aux_pin_oe_o)
      `CHK("aux_meas", !v[0], aux_meas_en_o)
    end
    $display("test field_codes done");
    wr(`TLF_IDX_CFG3, 8'h02);
    wr(`TLF_IDX_PIN_CFG, 8'h02);
    wr(`TLF_IDX_LIMIT, 8'h00);
    i_far.drive(1'b0);
    settle(8);
    `CHK("irq", 1'b1, irq_o)
    i_far.drive(1'b1);
    rd(`TLF_IDX_THERM_STAT, 8'h01, 1'b0);
    rd(`TLF_IDX_INT_STAT, 8'h20, 1'b0);
    settle(3);
    `CHK("irq", 1'b0, irq_o)
    wr(`TLF_IDX_PIN_CFG, 8'h03);
    wr(`TLF_IDX_INT_MASK, 8'h20);
    i_far.drive(1'b0);
    settle(8);
    `CHK("irq", 1'b0, irq_o)
    `CHK("alert", 1'b1, aux_pin_o)
    i_far.drive(1'b1);
    wr(`TLF_IDX_INT_MASK, 8'h00);
    settle(3);
    `CHK("irq", 1'b1, irq_o)
    `CHK("alert", 1'b0, aux_pin_o)
    rd(`TLF_IDX_INT_STAT, 8'h20, 1'b0);
    rd(`TLF_IDX_THERM_STAT, 8'h01, 1'b0);
    $display("test zero_limit done");
    // Fifty cycles low gives two ticks, seventy gives three
    wr(`TLF_IDX_LIMIT, 8'h02);
    wr(`TLF_IDX_CFG3, 8'h06);
    i_far.drive(1'b0);
    settle(10);
    `CHK("full_speed", 1'b1, ctl_o.full_speed)
    repeat (39) @(posedge clk_i);
    i_far.drive(1'b1);
    settle(4);
    `CHK("full_speed", 1'b0, ctl_o.full_speed)
    rd(`TLF_IDX_INT_STAT, 8'h00, 1'b0);
    rd(`TLF_IDX_THERM_STAT, 8'h02, 1'b0);
    i_far.drive(1'b0);
    repeat (69) @(posedge clk_i);
    i_far.drive(1'b1);
    settle(2);
    rd(`TLF_IDX_INT_STAT, 8'h20, 1'b0);
    rd(`TLF_IDX_THERM_STAT, 8'h03, 1'b0);
    $display("test timed_limit done");
    // Either enable alone must leave the input unwatched
    for (int i = 0; i < 2; i++) begin
      wr(`TLF_IDX_CFG3, i ? 8'h02 : 8'h00);
      wr(`TLF_IDX_PIN_CFG, i ? 8'h00 : 8'h02);
      i_far.drive(1'b0);
      settle(30);
      i_far.drive(1'b1);
      rd(`TLF_IDX_INT_STAT, 8'h00, 1'b0);
      rd(`TLF_IDX_THERM_STAT, 8'h00, 1'b0);
    end
    $display("test disabled done");
    settle(2);
    end_sim();
  end
endmodule
`default_nettype wire
